// *** fpl_defs.svh ***
// Constants for the four port output latches.
// Behaviour
// - Four separate 8-bit latches each drive their stored bits onto the eight pins of their port.
// - A read-modify-write read of a port returns that port's latch, not its pins.
// - Any other read of a port returns that port's pin levels as they come out of the two-stage synchroniser.
// - An external bus cycle on port 0 loads its latch with all ones, losing the old value.
// - Reset sets every bit of all four latches to one.
// - The four latches decode at special function addresses sixteen apart, starting at port 0.
`ifndef FPL_DEFS_SVH
`define FPL_DEFS_SVH

`define FPL_PORT0_ADDR 8'h80
`define FPL_PORT1_ADDR 8'h90
`define FPL_PORT2_ADDR 8'ha0
`define FPL_PORT3_ADDR 8'hb0
`define FPL_PORT_STRIDE_LSB 4
`define FPL_PORT_COUNT 3'h4
`define FPL_LATCH_RESET 8'hff
`define FPL_BUS_FILL 8'hff
`define FPL_PIN_RESET 8'hff
`define FPL_UNMAPPED_READ 8'h00
`define FPL_SYNC_STAGES 2

`endif

// *** fpl_pkg.sv ***
// Types shared by the four port output latch design.
package fpl_pkg;

	typedef logic [7:0] fpl_byte_t;
	typedef logic [3:0][7:0] fpl_ports_t;
	typedef logic [1:0] fpl_index_t;

	typedef enum logic [2:0]
	{
		FPL_RSRC_NONE = 3'b001,
		FPL_RSRC_LATCH = 3'b010,
		FPL_RSRC_PIN = 3'b100
	} fpl_rsrc_e;

endpackage : fpl_pkg

// *** fpl_sync_if.sv ***
// Carrier for the raw and synchronised pin levels of all four ports.
`timescale 1ns/1ps
interface fpl_sync_if;
	import fpl_pkg::*;

	fpl_ports_t pins_raw;
	fpl_ports_t pins_sync;

	modport sync
	(
		input pins_raw,
		output pins_sync
	);

	modport core
	(
		output pins_raw,
		input pins_sync
	);

endinterface : fpl_sync_if

// *** fpl_pin_sync.sv ***
// Two-stage synchroniser for the port pin levels.
`timescale 1ns/1ps
`include "fpl_defs.svh"
module fpl_pin_sync
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Pin levels
	fpl_sync_if.sync pins
);
	import fpl_pkg::*;

	fpl_ports_t meta_q;
	fpl_ports_t sync_q;

	// The first stage feeds only the second, so metastability never reaches decode logic.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			meta_q <= {4{`FPL_PIN_RESET}};
			sync_q <= {4{`FPL_PIN_RESET}};
		end
		else
		begin
			meta_q <= pins.pins_raw;
			sync_q <= meta_q;
		end
	end

	assign pins.pins_sync = sync_q;

endmodule : fpl_pin_sync

// *** fpl_top.sv ***
// Four 8-bit port output latches with special function register access.
`timescale 1ns/1ps
`include "fpl_defs.svh"
module fpl_top
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Special function register access from the core
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr_en,
	input wire fpl_pkg::fpl_byte_t sfr_wr_data,
	input wire logic sfr_rd_en,
	input wire logic sfr_rd_rmw,
	output fpl_pkg::fpl_byte_t sfr_rd_data,
	output logic sfr_rd_valid,
	output logic sfr_rd_hit,
	// External bus activity on port 0
	input wire logic ext_bus_cycle,
	// Port pins
	input wire fpl_pkg::fpl_ports_t port_pin_in,
	output fpl_pkg::fpl_ports_t port_pin_out
);
	import fpl_pkg::*;

	// One element per port keeps each latch in a process of its own without two writers.
	fpl_byte_t latch_q [4];
	fpl_byte_t rd_data_q;
	logic rd_valid_q;
	logic rd_hit_q;
	fpl_rsrc_e rsrc;
	logic [2:0] rd_sel;
	logic [2:0] wr_sel;

	fpl_sync_if pin_bus ();

	assign pin_bus.pins_raw = port_pin_in;

	fpl_pin_sync u_pin_sync
	(
		.ref_clk(ref_clk),
		.srst(srst),
		.pins(pin_bus.sync)
	);

	// Returns {hit, index}; the four ports sit sixteen addresses apart, starting at port 0.
	function automatic logic [2:0] fpl_decode(input logic [7:0] addr);
		logic [7:0] diff;
		logic [3:0] slot;
		diff = addr - `FPL_PORT0_ADDR;
		slot = diff[7:`FPL_PORT_STRIDE_LSB];
		if ((diff[`FPL_PORT_STRIDE_LSB-1:0] == 4'h0) && (slot < {1'b0, `FPL_PORT_COUNT}))
		begin
			fpl_decode = {1'b1, slot[1:0]};
		end
		else
		begin
			fpl_decode = 3'h0;
		end
	endfunction : fpl_decode

	assign rd_sel = fpl_decode(sfr_addr);
	assign wr_sel = fpl_decode(sfr_addr);

	always_comb
	begin
		if (!rd_sel[2])
		begin
			rsrc = FPL_RSRC_NONE;
		end
		else if (sfr_rd_rmw)
		begin
			rsrc = FPL_RSRC_LATCH;
		end
		else
		begin
			rsrc = FPL_RSRC_PIN;
		end
	end

	// Port 0 latch: a bus cycle beats a software write in the same cycle.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			latch_q[0] <= `FPL_LATCH_RESET;
		end
		else if (ext_bus_cycle)
		begin
			latch_q[0] <= `FPL_BUS_FILL;
		end
		else if (sfr_wr_en && wr_sel[2] && (wr_sel[1:0] == 2'h0))
		begin
			latch_q[0] <= sfr_wr_data;
		end
	end

	// Ports 1 to 3 only ever change by reset or by a write.
	for (genvar i = 1; i < 4; i++)
	begin : g_latch
		always_ff @(posedge ref_clk)
		begin
			if (srst)
			begin
				latch_q[i] <= `FPL_LATCH_RESET;
			end
			else if (sfr_wr_en && wr_sel[2] && (wr_sel[1:0] == fpl_index_t'(i)))
			begin
				latch_q[i] <= sfr_wr_data;
			end
		end
	end

	// Reads are answered one cycle later; the latch source shows the value before a same-cycle write.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			rd_data_q <= `FPL_UNMAPPED_READ;
			rd_valid_q <= 1'b0;
			rd_hit_q <= 1'b0;
		end
		else
		begin
			rd_valid_q <= sfr_rd_en;
			rd_hit_q <= sfr_rd_en && rd_sel[2];
			if (sfr_rd_en)
			begin
				unique case (rsrc)
					FPL_RSRC_LATCH: rd_data_q <= latch_q[rd_sel[1:0]];
					FPL_RSRC_PIN: rd_data_q <= pin_bus.pins_sync[rd_sel[1:0]];
					FPL_RSRC_NONE: rd_data_q <= `FPL_UNMAPPED_READ;
				endcase
			end
		end
	end

	assign port_pin_out = {latch_q[3], latch_q[2], latch_q[1], latch_q[0]};
	assign sfr_rd_data = rd_data_q;
	assign sfr_rd_valid = rd_valid_q;
	assign sfr_rd_hit = rd_hit_q;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	sequence s_pin_read;
		sfr_rd_en && !sfr_rd_rmw && rd_sel[2];
	endsequence

	sequence s_rmw_read;
		sfr_rd_en && sfr_rd_rmw && rd_sel[2];
	endsequence

	// Two edges out of reset let real pin levels reach both synchroniser stages.
	sequence s_sync_settled;
		!srst[*2];
	endsequence

	a_reset_all_ones: assert property (disable iff (1'b0)
		srst |=> (port_pin_out == {4{8'hff}}))
		else $error("latches not all ones after reset");

	a_bus_fill_port0: assert property (ext_bus_cycle |=> (port_pin_out[0] == 8'hff))
		else $error("bus cycle did not fill port 0 latch");

	a_bus_beats_write: assert property (ext_bus_cycle && sfr_wr_en && (sfr_addr == 8'h80)
		|=> (port_pin_out[0] == 8'hff))
		else $error("software write to port 0 won over a bus cycle");

	a_rmw_read_latch: assert property (s_rmw_read |=>
		(sfr_rd_data == $past(latch_q[rd_sel[1:0]])) && sfr_rd_hit)
		else $error("read-modify-write read did not return the latch");

	a_sync_two_stage: assert property (!srst[*3] |->
		(pin_bus.pins_sync == $past(port_pin_in, 2)))
		else $error("pin synchroniser depth is not two");

	a_sync_reset_ones: assert property (disable iff (1'b0)
		srst |=> (pin_bus.pins_sync == {4{8'hff}}))
		else $error("pin synchroniser not all ones after reset");

	a_reset_read_clear: assert property (disable iff (1'b0)
		srst |=> (sfr_rd_data == 8'h00) && !sfr_rd_valid && !sfr_rd_hit)
		else $error("read outputs not cleared by reset");

	a_read_valid_pulse: assert property (1'b1 |=> (sfr_rd_valid == $past(sfr_rd_en)))
		else $error("read answer did not follow its strobe by one cycle");

	a_read_data_hold: assert property (!sfr_rd_en |=> $stable(sfr_rd_data))
		else $error("read data changed without a read");

	a_read_port_hit: assert property (sfr_rd_en && (sfr_addr[3:0] == 4'h0)
		&& (sfr_addr[7:4] >= 4'h8) && (sfr_addr[7:4] <= 4'hb) |=> sfr_rd_hit)
		else $error("read at a port address not flagged as a hit");

	a_read_no_hit: assert property (sfr_rd_en && ((sfr_addr[3:0] != 4'h0)
		|| (sfr_addr[7:4] < 4'h8) || (sfr_addr[7:4] > 4'hb)) |=> !sfr_rd_hit)
		else $error("read off the port addresses flagged as a hit");

	a_unmapped_zero: assert property (sfr_rd_en && !rd_sel[2] |=>
		(sfr_rd_data == 8'h00) && !sfr_rd_hit && sfr_rd_valid)
		else $error("unmapped read not answered with zero");

	for (genvar k = 0; k < 4; k++)
	begin : g_chk
		a_write_decode: assert property (sfr_wr_en
			&& (sfr_addr == (8'h80 + 8'(k * 16))) && !(k == 0 && ext_bus_cycle)
			|=> (port_pin_out[k] == $past(sfr_wr_data)))
			else $error("write at port address did not reach its latch");

		a_port_hold: assert property (!(sfr_wr_en && sfr_addr == (8'h80 + 8'(k * 16)))
			&& !(k == 0 && ext_bus_cycle) |=> $stable(port_pin_out[k]))
			else $error("port latch changed without a write");

		// A pin read too soon after reset sees the flushed synchroniser, so it is left out.
		a_pin_read_sync: assert property (s_sync_settled ##1 s_pin_read
			##0 (rd_sel[1:0] == 2'(k)) |=> (sfr_rd_data == $past(port_pin_in[k], 3)))
			else $error("pin read did not return synchronised pins");
	end

endmodule : fpl_top

// *** fpl_pin_model.sv ***
// Far-side model of the port pins, which loads the latch outputs.
`timescale 1ns/1ps
module fpl_pin_model
(
	// Port levels
	input wire fpl_pkg::fpl_ports_t drive,
	input wire fpl_pkg::fpl_ports_t pull,
	output fpl_pkg::fpl_ports_t level
);
	import fpl_pkg::*;
	// An outside load may pull chosen bits away from the driven level.
	// So a pin read can be told apart from a latch read.
	assign level = drive ^ pull;
endmodule : fpl_pin_model

// *** tb_four_port_output_latches.sv ***
// Self-checking bench for the four port output latches.
`timescale 1ns/1ps
module tb_four_port_output_latches;
	import fpl_pkg::*;
	logic ref_clk = 0;
	logic srst = 1;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr_en = 0, sfr_rd_en = 0, sfr_rd_rmw = 0, ext_bus_cycle = 0;
	fpl_byte_t sfr_wr_data = 8'h00, sfr_rd_data;
	logic sfr_rd_valid, sfr_rd_hit;
	fpl_ports_t pull = '0, pin_in, pin_out;
	int miscompares = 0, checks_done = 0, cycles = 0;
	// Columns: address, data written, expected pin read with low nibble pulled.
	fpl_byte_t rows [4][3] = '{'{8'h80, 8'h3c, 8'h33}, '{8'h90, 8'h5a, 8'h55},
		'{8'ha0, 8'h01, 8'h0e}, '{8'hb0, 8'h80, 8'h8f}};

	fpl_top fpl_top_i
	(
		.ref_clk(ref_clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
		.sfr_wr_data(sfr_wr_data), .sfr_rd_en(sfr_rd_en), .sfr_rd_rmw(sfr_rd_rmw),
		.sfr_rd_data(sfr_rd_data), .sfr_rd_valid(sfr_rd_valid), .sfr_rd_hit(sfr_rd_hit),
		.ext_bus_cycle(ext_bus_cycle), .port_pin_in(pin_in), .port_pin_out(pin_out)
	);
	fpl_pin_model fpl_pin_model_i (.drive(pin_out), .pull(pull), .level(pin_in));

	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic final_report();
		if (miscompares == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report

	// The whole run needs about 60 cycles, so this only catches a hang.
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			miscompares = miscompares + 1;
			final_report();
		end
	end

	task automatic cmp(input fpl_byte_t got, input fpl_byte_t exp);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic acc(input logic wr, input logic rd, input logic rmw, input logic [7:0] a,
		input fpl_byte_t d);
		@(posedge ref_clk);
		#1;
		{sfr_wr_en, sfr_rd_en, sfr_rd_rmw, sfr_addr, sfr_wr_data} = {wr, rd, rmw, a, d};
		@(posedge ref_clk);
		#1;
		{sfr_wr_en, sfr_rd_en, sfr_rd_rmw} = 3'h0;
	endtask : acc

	task automatic rd(input logic rmw, input logic [7:0] a, input fpl_byte_t exp,
		input logic hit);
		acc(0, 1, rmw, a, 8'h00);
		cmp({6'h00, sfr_rd_valid, sfr_rd_hit}, {6'h00, 1'b1, hit});
		cmp(sfr_rd_data, exp);
	endtask : rd

	initial
	begin
		repeat (12) @(posedge ref_clk);
		#1;
		srst = 0;
		for (int i = 0; i < 4; i++)
			rd(1, rows[i][0], 8'hff, 1);
		for (int i = 0; i < 4; i++)
		begin
			acc(1, 0, 0, rows[i][0], rows[i][1]);
			cmp(pin_out[i], rows[i][1]);
		end
		pull = {4{8'h0f}};
		// The synchroniser still holds the old pins for this read.
		rd(0, 8'h80, rows[0][1], 1);
		for (int i = 0; i < 4; i++)
		begin
			rd(1, rows[i][0], rows[i][1], 1);
			rd(0, rows[i][0], rows[i][2], 1);
		end
		acc(1, 1, 1, 8'h90, 8'h11);
		cmp(sfr_rd_data, rows[1][1]);
		cmp(pin_out[1], 8'h11);
		rd(1, 8'h88, 8'h00, 0);
		rd(0, 8'hc0, 8'h00, 0);
		acc(1, 0, 0, 8'h81, 8'h00);
		cmp(pin_out[0], rows[0][1]);
		ext_bus_cycle = 1;
		acc(1, 0, 0, 8'h80, 8'h00);
		ext_bus_cycle = 0;
		cmp(pin_out[0], 8'hff);
		srst = 1;
		@(posedge ref_clk);
		#1;
		srst = 0;
		for (int i = 0; i < 4; i++)
			cmp(pin_out[i], 8'hff);
		final_report();
	end
endmodule : tb_four_port_output_latches
